/* src/filter_commit_pkg.sv */
// Constants shared by the filter output and commit logic
package filter_commit_pkg;
  // ************************************************************
  // Register map, byte addresses
  // ************************************************************
  localparam logic [7:0] COMMIT_CTRL_ADDR = 8'h00;
  localparam logic [7:0] CAM_MASK_ADDR = 8'h04;
  localparam logic [7:0] TREE_MASK_ADDR = 8'h08;
  localparam logic [7:0] CASE_EN_ADDR = 8'h0c;
  localparam logic [7:0] PART_TABLE_ADDR = 8'h10;
  localparam logic [7:0] COMMIT_STATUS_ADDR = 8'h14;
  localparam logic [7:0] ROOT_KEY_BASE_ADDR = 8'h40;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int ROOT_KEYS = 16;
  localparam int ROOT_IDX_W = 4;

  // ************************************************************
  // Commit control fields and reset values
  // ************************************************************
  localparam int COMMIT_CAM_BIT = 0;
  localparam int COMMIT_TREE_BIT = 1;
  localparam int COMMIT_W = 2;
  localparam logic [31:0] CFG_RESET = 32'h0000_0000;

  // ************************************************************
  // Output record field widths
  // ************************************************************
  localparam int MAC_W = 48;
  localparam int VID_W = 12;
  localparam int LEN_W = 16;
  localparam int IP_W = 128;
  localparam int QOS_W = 22;
  localparam int SCEN_W = 5;
  localparam int BIN_W = 4;
  localparam int HPROF_W = 4;
  localparam int CH8_W = 8;
  localparam int CH16_W = 16;
  localparam int CH24_W = 24;
  localparam int TAG_W = 12;
  localparam int ACL_N = 32;
  localparam int ACL_E_W = 6;
  localparam int ACL_W = ACL_N * ACL_E_W;
  localparam int PORT_TAG_LSB = 0;
  localparam int PORT_TAG_MSB = 15;
  localparam int W4_LSB = 16;
  localparam int W4_MSB = 19;
endpackage

/* src/shadow_reg.sv */
// Shadowed configuration register with an active copy
`timescale 1ns/1ps
module shadow_reg #(
  parameter int WIDTH = 32,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic wr_en_i,
  input wire logic [WIDTH-1:0] wr_data_i,
  input wire logic apply_i,
  output logic [WIDTH-1:0] active_o
);
  logic [WIDTH-1:0] shadow_q;

  // Software writes only reach the shadow copy
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      shadow_q <= RESET_VAL;
    end else if (wr_en_i) begin
      shadow_q <= wr_data_i;
    end
  end

  // Active copy loads the shadow on a commit
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      active_o <= RESET_VAL;
    end else if (apply_i) begin
      active_o <= shadow_q;
    end
  end
endmodule

/* src/filter_output_commit.sv */
// Filter final stage: shadow commit registers and output record
`timescale 1ns/1ps
module filter_output_commit
  import filter_commit_pkg::*;
#(
  parameter int CAM_MASK_W = 32,
  parameter int TREE_MASK_W = 4,
  parameter int CASE_EN_W = 32,
  parameter int PART_W = 32,
  parameter int ROOT_KEY_W = 32
) (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [ADDR_W-1:0] paddr_i,
  input wire logic [DATA_W-1:0] pwdata_i,
  output logic [DATA_W-1:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Lookup pipeline status and active configuration
  input wire logic frame_active_i,
  output logic [CAM_MASK_W-1:0] cam_slice_enable_mask_o,
  output logic [TREE_MASK_W-1:0] tree_slice_enable_mask_o,
  output logic [CASE_EN_W-1:0] tree_case_enable_o,
  output logic [PART_W-1:0] tree_root_to_partition_table_o,
  output logic [ROOT_KEYS*ROOT_KEY_W-1:0] tree_top_level_keys_o,
  // Per-frame inputs from the last slice
  input wire logic in_valid_i,
  input wire logic [MAC_W-1:0] dest_mac_key_i,
  input wire logic [MAC_W-1:0] src_mac_key_i,
  input wire logic [VID_W-1:0] first_vlan_key_i,
  input wire logic [VID_W-1:0] second_vlan_key_i,
  input wire logic [LEN_W-1:0] ip_length_key_i,
  input wire logic [IP_W-1:0] src_ip_key_i,
  input wire logic [IP_W-1:0] dest_ip_key_i,
  input wire logic [QOS_W-1:0] qos_i,
  input wire logic [SCEN_W-1:0] scenario_i,
  input wire logic [BIN_W-1:0] length_bin_key_i,
  input wire logic [HPROF_W-1:0] hash_profile_i,
  input wire logic [CH8_W-1:0] byte_action_channel_a_i,
  input wire logic [CH8_W-1:0] byte_action_channel_b_i,
  input wire logic [CH8_W-1:0] byte_action_channel_c_i,
  input wire logic [CH16_W-1:0] half_action_channel_a_i,
  input wire logic [CH16_W-1:0] half_action_channel_b_i,
  input wire logic [CH24_W-1:0] wide_action_channel_i,
  input wire logic [TAG_W-1:0] early_tag_a_i,
  input wire logic [TAG_W-1:0] early_tag_b_i,
  input wire logic [TAG_W-1:0] late_tag_a_i,
  input wire logic [TAG_W-1:0] late_tag_b_i,
  input wire logic [ACL_W-1:0] egress_acl_hit_vector_i,
  input wire logic final_switch_i,
  input wire logic final_route_i,
  // Output record to the post-filter rewrite stage
  output logic out_valid_o,
  output logic [MAC_W-1:0] dest_mac_key_o,
  output logic [MAC_W-1:0] src_mac_key_o,
  output logic [VID_W-1:0] first_vlan_key_o,
  output logic [VID_W-1:0] second_vlan_key_o,
  output logic [LEN_W-1:0] ip_length_key_o,
  output logic [IP_W-1:0] src_ip_key_o,
  output logic [IP_W-1:0] dest_ip_key_o,
  output logic [QOS_W-1:0] qos_o,
  output logic [SCEN_W-1:0] scenario_o,
  output logic [BIN_W-1:0] length_bin_key_o,
  output logic [HPROF_W-1:0] hash_profile_o,
  output logic [CH8_W-1:0] byte_action_channel_a_o,
  output logic [CH8_W-1:0] byte_action_channel_b_o,
  output logic [CH8_W-1:0] byte_action_channel_c_o,
  output logic [CH16_W-1:0] half_action_channel_a_o,
  output logic [CH16_W-1:0] half_action_channel_b_o,
  output logic [CH24_W-1:0] wide_action_channel_o,
  output logic [TAG_W-1:0] early_tag_a_o,
  output logic [TAG_W-1:0] early_tag_b_o,
  output logic [TAG_W-1:0] late_tag_a_o,
  output logic [TAG_W-1:0] late_tag_b_o,
  output logic [ACL_W-1:0] egress_acl_hit_vector_o,
  output logic switch_taken_flag_o,
  output logic route_taken_flag_o,
  output logic chan_a_matches_vlan1_o,
  output logic chan_b_matches_vlan2_o,
  // Next-hop table request
  output logic nh_req_o,
  output logic [CH24_W-1:0] nh_key_o
);
  // ************************************************************
  // APB decode
  // ************************************************************
  logic setup;
  logic wr_fire;
  logic wr_cam;
  logic wr_tree_mask;
  logic wr_case;
  logic wr_part;
  logic wr_commit;
  logic [ROOT_KEYS-1:0] wr_root;
  logic root_hit;
  logic [ROOT_IDX_W-1:0] root_idx;
  logic [COMMIT_W-1:0] pending_q;
  logic [COMMIT_W-1:0] apply;
  logic [DATA_W-1:0] rd_mux;
  logic rd_err;

  assign setup = psel_i & ~penable_i;
  // Write takes effect at the completing access edge
  assign wr_fire = psel_i & penable_i & pready_o & pwrite_i;
  assign root_hit = (paddr_i >= ROOT_KEY_BASE_ADDR) &&
                    (paddr_i[1:0] == 2'h0) &&
                    (paddr_i < ROOT_KEY_BASE_ADDR + 8'(ROOT_KEYS * 4));
  assign root_idx = ROOT_IDX_W'((paddr_i - ROOT_KEY_BASE_ADDR) >> 2);
  assign wr_cam = wr_fire && (paddr_i == CAM_MASK_ADDR);
  assign wr_tree_mask = wr_fire && (paddr_i == TREE_MASK_ADDR);
  assign wr_case = wr_fire && (paddr_i == CASE_EN_ADDR);
  assign wr_part = wr_fire && (paddr_i == PART_TABLE_ADDR);
  assign wr_commit = wr_fire && (paddr_i == COMMIT_CTRL_ADDR);

  // Per-key write strobes
  always_comb begin
    wr_root = '0;
    if (wr_fire && root_hit) begin
      wr_root[root_idx] = 1'b1;
    end
  end

  // Read mux returning the active copies
  always_comb begin
    rd_mux = '0;
    rd_err = 1'b0;
    if (root_hit) begin
      rd_mux = DATA_W'(tree_top_level_keys_o[root_idx*ROOT_KEY_W +:
                                             ROOT_KEY_W]);
    end else begin
      unique case (paddr_i)
        COMMIT_CTRL_ADDR: rd_mux = '0; // Write-only
        CAM_MASK_ADDR: rd_mux = DATA_W'(cam_slice_enable_mask_o);
        TREE_MASK_ADDR: rd_mux = DATA_W'(tree_slice_enable_mask_o);
        CASE_EN_ADDR: rd_mux = DATA_W'(tree_case_enable_o);
        PART_TABLE_ADDR: rd_mux = DATA_W'(tree_root_to_partition_table_o);
        COMMIT_STATUS_ADDR: rd_mux = DATA_W'(pending_q);
        default: rd_err = 1'b1;
      endcase
    end
  end

  // ************************************************************
  // APB response registers
  // ************************************************************
  // Ready raised for the access phase that follows setup
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
    end else begin
      pready_o <= setup;
      pslverr_o <= setup & rd_err;
    end
  end

  // Read data captured in the setup cycle
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      prdata_o <= '0;
    end else if (setup) begin
      prdata_o <= pwrite_i ? '0 : rd_mux;
    end
  end

  // ************************************************************
  // Commit control
  // ************************************************************
  // apply only between frames
  assign apply = pending_q & {COMMIT_W{~frame_active_i}};

  // Pending commit bits, a new request beats the clear
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      pending_q <= '0;
    end else begin
      for (int i = 0; i < COMMIT_W; i++) begin
        if (wr_commit && pwdata_i[i]) begin
          pending_q[i] <= 1'b1;
        end else if (apply[i]) begin
          pending_q[i] <= 1'b0;
        end
      end
    end
  end

  // ************************************************************
  // Shadowed configuration registers
  // ************************************************************
  // CAM group commit
  shadow_reg #(.WIDTH(CAM_MASK_W), .RESET_VAL(CAM_MASK_W'(CFG_RESET)))
  u_cam_mask (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .wr_en_i(wr_cam),
    .wr_data_i(CAM_MASK_W'(pwdata_i)),
    .apply_i(apply[COMMIT_CAM_BIT]),
    .active_o(cam_slice_enable_mask_o)
  );

  shadow_reg #(.WIDTH(TREE_MASK_W), .RESET_VAL(TREE_MASK_W'(CFG_RESET)))
  u_tree_mask (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .wr_en_i(wr_tree_mask),
    .wr_data_i(TREE_MASK_W'(pwdata_i)),
    .apply_i(apply[COMMIT_TREE_BIT]),
    .active_o(tree_slice_enable_mask_o)
  );

  shadow_reg #(.WIDTH(CASE_EN_W), .RESET_VAL(CASE_EN_W'(CFG_RESET)))
  u_case_en (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .wr_en_i(wr_case),
    .wr_data_i(CASE_EN_W'(pwdata_i)),
    .apply_i(apply[COMMIT_TREE_BIT]),
    .active_o(tree_case_enable_o)
  );

  shadow_reg #(.WIDTH(PART_W), .RESET_VAL(PART_W'(CFG_RESET)))
  u_part (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .wr_en_i(wr_part),
    .wr_data_i(PART_W'(pwdata_i)),
    .apply_i(apply[COMMIT_TREE_BIT]),
    .active_o(tree_root_to_partition_table_o)
  );

  // Sixteen root keys share the tree commit bit
  for (genvar k = 0; k < ROOT_KEYS; k++) begin : g_root
    shadow_reg #(.WIDTH(ROOT_KEY_W), .RESET_VAL(ROOT_KEY_W'(CFG_RESET)))
    u_key (
      .sys_clk_i(sys_clk_i),
      .rst_i(rst_i),
      .wr_en_i(wr_root[k]),
      .wr_data_i(ROOT_KEY_W'(pwdata_i)),
      .apply_i(apply[COMMIT_TREE_BIT]),
      .active_o(tree_top_level_keys_o[k*ROOT_KEY_W +: ROOT_KEY_W])
    );
  end

  // ************************************************************
  // Output record
  // ************************************************************
  // valid follows in_valid_i one cycle later; every record field is registered below
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      out_valid_o <= 1'b0;
    end else begin
      out_valid_o <= in_valid_i;
    end
  end

  // Record fields captured per frame
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      dest_mac_key_o <= '0;
      src_mac_key_o <= '0;
      first_vlan_key_o <= '0;
      second_vlan_key_o <= '0;
      ip_length_key_o <= '0;
      src_ip_key_o <= '0;
      dest_ip_key_o <= '0;
      qos_o <= '0;
      scenario_o <= '0;
      length_bin_key_o <= '0;
      hash_profile_o <= '0;
      byte_action_channel_a_o <= '0;
      byte_action_channel_b_o <= '0;
      byte_action_channel_c_o <= '0;
      half_action_channel_a_o <= '0;
      half_action_channel_b_o <= '0;
      wide_action_channel_o <= '0;
      early_tag_a_o <= '0;
      early_tag_b_o <= '0;
      late_tag_a_o <= '0;
      late_tag_b_o <= '0;
      egress_acl_hit_vector_o <= '0;
    end else if (in_valid_i) begin
      dest_mac_key_o <= dest_mac_key_i;
      src_mac_key_o <= src_mac_key_i;
      first_vlan_key_o <= first_vlan_key_i;
      second_vlan_key_o <= second_vlan_key_i;
      ip_length_key_o <= ip_length_key_i;
      src_ip_key_o <= src_ip_key_i;
      dest_ip_key_o <= dest_ip_key_i;
      qos_o <= qos_i;
      scenario_o <= scenario_i;
      length_bin_key_o <= length_bin_key_i;
      hash_profile_o <= hash_profile_i;
      byte_action_channel_a_o <= byte_action_channel_a_i;
      byte_action_channel_b_o <= byte_action_channel_b_i;
      byte_action_channel_c_o <= byte_action_channel_c_i;
      half_action_channel_a_o <= half_action_channel_a_i;
      half_action_channel_b_o <= half_action_channel_b_i;
      wide_action_channel_o <= wide_action_channel_i;
      early_tag_a_o <= early_tag_a_i;
      early_tag_b_o <= early_tag_b_i;
      late_tag_a_o <= late_tag_a_i;
      late_tag_b_o <= late_tag_b_i;
      egress_acl_hit_vector_o <= egress_acl_hit_vector_i;
    end
  end

  // ************************************************************
  // Action flags and next-hop request
  // ************************************************************
  // Flags computed per frame
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      switch_taken_flag_o <= 1'b0;
      route_taken_flag_o <= 1'b0;
      chan_a_matches_vlan1_o <= 1'b0;
      chan_b_matches_vlan2_o <= 1'b0;
    end else if (in_valid_i) begin
      route_taken_flag_o <= final_route_i;
      switch_taken_flag_o <= final_switch_i & ~final_route_i;
      chan_a_matches_vlan1_o <=
        (half_action_channel_a_i[VID_W-1:0] == first_vlan_key_i);
      chan_b_matches_vlan2_o <=
        (half_action_channel_b_i[VID_W-1:0] == second_vlan_key_i);
    end
  end

  // One-cycle lookup request when routing
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      nh_req_o <= 1'b0;
      nh_key_o <= '0;
    end else begin
      nh_req_o <= in_valid_i & final_route_i;
      if (in_valid_i && final_route_i) begin
        nh_key_o <= wide_action_channel_i;
      end
    end
  end
endmodule

/* verification/filter_output_commit_checker.sv */
// Port assertions for the filter output commit block
`timescale 1ns/1ps
module filter_output_commit_checker
  import filter_commit_pkg::*;
#(
  parameter int CAM_MASK_W = 32,
  parameter int TREE_MASK_W = 4
) (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic frame_active_i,
  input wire logic in_valid_i,
  input wire logic final_switch_i,
  input wire logic final_route_i,
  input wire logic [MAC_W-1:0] dest_mac_key_i,
  input wire logic [VID_W-1:0] first_vlan_key_i,
  input wire logic [CH16_W-1:0] half_action_channel_a_i,
  input wire logic [CH24_W-1:0] wide_action_channel_i,
  input wire logic [CAM_MASK_W-1:0] cam_slice_enable_mask_o,
  input wire logic [TREE_MASK_W-1:0] tree_slice_enable_mask_o,
  input wire logic out_valid_o,
  input wire logic [MAC_W-1:0] dest_mac_key_o,
  input wire logic switch_taken_flag_o,
  input wire logic route_taken_flag_o,
  input wire logic chan_a_matches_vlan1_o,
  input wire logic nh_req_o,
  input wire logic [CH24_W-1:0] nh_key_o
);
  // Expected flag causes at the inputs
  logic vid_eq;
  logic sw_only;
  assign vid_eq = half_action_channel_a_i[VID_W-1:0] == first_vlan_key_i;
  assign sw_only = final_switch_i && !final_route_i;

  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (rst_i);

  // Frame accepted with a route decision
  sequence s_routed;
    in_valid_i && final_route_i;
  endsequence
  // Record presented one cycle later
  sequence s_record;
    out_valid_o && dest_mac_key_o == $past(dest_mac_key_i);
  endsequence

  property p_nh_req;
    s_routed |=> nh_req_o && nh_key_o == $past(wide_action_channel_i);
  endproperty
  a_nh_req: assert property (p_nh_req)
    else $error("next-hop request missing or key wrong");
  property p_nh_quiet;
    !(in_valid_i && final_route_i) |=> !nh_req_o;
  endproperty
  a_nh_quiet: assert property (p_nh_quiet)
    else $error("next-hop request without route");
  property p_record;
    in_valid_i |=> s_record;
  endproperty
  a_record: assert property (p_record)
    else $error("record not presented after frame");
  property p_hold;
    !in_valid_i |=> !out_valid_o && $stable(dest_mac_key_o);
  endproperty
  a_hold: assert property (p_hold)
    else $error("record changed without frame");
  property p_excl;
    !(switch_taken_flag_o && route_taken_flag_o);
  endproperty
  a_excl: assert property (p_excl)
    else $error("switch and route flags both set");
  property p_flags;
    in_valid_i |=> route_taken_flag_o == $past(final_route_i)
      && switch_taken_flag_o == $past(sw_only);
  endproperty
  a_flags: assert property (p_flags)
    else $error("forwarding flags wrong");
  property p_vlan;
    in_valid_i |=> chan_a_matches_vlan1_o == $past(vid_eq);
  endproperty
  a_vlan: assert property (p_vlan)
    else $error("vlan match flag wrong");
  property p_cam_edge;
    $changed(cam_slice_enable_mask_o) |-> !$past(frame_active_i);
  endproperty
  a_cam_edge: assert property (p_cam_edge)
    else $error("cam config changed inside a frame");
  property p_tree_edge;
    $changed(tree_slice_enable_mask_o) |-> !$past(frame_active_i);
  endproperty
  a_tree_edge: assert property (p_tree_edge)
    else $error("tree config changed inside a frame");
endmodule

bind filter_output_commit filter_output_commit_checker #(
  .CAM_MASK_W(CAM_MASK_W),
  .TREE_MASK_W(TREE_MASK_W)
) checker_u (
  .sys_clk_i, .rst_i, .frame_active_i, .in_valid_i, .final_switch_i,
  .final_route_i, .dest_mac_key_i, .first_vlan_key_i,
  .half_action_channel_a_i, .wide_action_channel_i,
  .cam_slice_enable_mask_o, .tree_slice_enable_mask_o, .out_valid_o,
  .dest_mac_key_o, .switch_taken_flag_o, .route_taken_flag_o,
  .chan_a_matches_vlan1_o, .nh_req_o, .nh_key_o
);

/* verification/next_hop_model.sv */
// Rewrite stage and next-hop table model
`timescale 1ns/1ps
module next_hop_model
  import filter_commit_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic rec_valid_i,
  input wire logic nh_req_i,
  input wire logic [CH24_W-1:0] nh_key_i,
  output logic [15:0] lookups_o,
  output logic [15:0] records_o,
  output logic [CH24_W-1:0] last_key_o
);
  // Records taken by the rewrite stage
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      records_o <= '0;
    end else if (rec_valid_i) begin
      records_o <= records_o + 16'h0001;
    end
  end
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      lookups_o <= '0;
      last_key_o <= '0;
    end else if (nh_req_i) begin
      lookups_o <= lookups_o + 16'h0001;
      last_key_o <= nh_key_i;
    end
  end
endmodule

/* verification/filter_output_commit_tb.sv */
// Testbench for the filter output commit block
`timescale 1ns/1ps
module filter_output_commit_tb;
  import filter_commit_pkg::*;
  logic sys_clk_i, rst_i, psel_i, penable_i, pwrite_i, frame_active_i;
  logic in_valid_i, final_switch_i, final_route_i, err;
  logic [ADDR_W-1:0] paddr_i;
  logic [DATA_W-1:0] pwdata_i, prdata_o, rd;
  logic pready_o, pslverr_o, out_valid_o, nh_req_o;
  logic switch_taken_flag_o, route_taken_flag_o;
  logic chan_a_matches_vlan1_o, chan_b_matches_vlan2_o;
  logic [31:0] cam_slice_enable_mask_o, tree_case_enable_o;
  logic [31:0] tree_root_to_partition_table_o;
  logic [3:0] tree_slice_enable_mask_o;
  logic [ROOT_KEYS*32-1:0] tree_top_level_keys_o;
  logic [CH24_W-1:0] nh_key_o, last_key;
  logic [15:0] lookups, records;
  logic [746:0] pat;
  wire [746:0] rec_o;
  int fails, compares, cycles;

  // Record fields are slices of one stimulus word
  filter_output_commit dut_u (
    .sys_clk_i, .rst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
    .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .frame_active_i,
    .cam_slice_enable_mask_o, .tree_slice_enable_mask_o,
    .tree_case_enable_o, .tree_root_to_partition_table_o,
    .tree_top_level_keys_o, .in_valid_i, .final_switch_i, .final_route_i,
    .dest_mac_key_i(pat[746:699]), .dest_mac_key_o(rec_o[746:699]),
    .src_mac_key_i(pat[698:651]), .src_mac_key_o(rec_o[698:651]),
    .first_vlan_key_i(pat[650:639]), .first_vlan_key_o(rec_o[650:639]),
    .second_vlan_key_i(pat[638:627]), .second_vlan_key_o(rec_o[638:627]),
    .ip_length_key_i(pat[626:611]), .ip_length_key_o(rec_o[626:611]),
    .src_ip_key_i(pat[610:483]), .src_ip_key_o(rec_o[610:483]),
    .dest_ip_key_i(pat[482:355]), .dest_ip_key_o(rec_o[482:355]),
    .qos_i(pat[354:333]), .qos_o(rec_o[354:333]),
    .scenario_i(pat[332:328]), .scenario_o(rec_o[332:328]),
    .length_bin_key_i(pat[327:324]), .length_bin_key_o(rec_o[327:324]),
    .hash_profile_i(pat[323:320]), .hash_profile_o(rec_o[323:320]),
    .byte_action_channel_a_i(pat[319:312]),
    .byte_action_channel_a_o(rec_o[319:312]),
    .byte_action_channel_b_i(pat[311:304]),
    .byte_action_channel_b_o(rec_o[311:304]),
    .byte_action_channel_c_i(pat[303:296]),
    .byte_action_channel_c_o(rec_o[303:296]),
    .half_action_channel_a_i(pat[295:280]),
    .half_action_channel_a_o(rec_o[295:280]),
    .half_action_channel_b_i(pat[279:264]),
    .half_action_channel_b_o(rec_o[279:264]),
    .wide_action_channel_i(pat[263:240]),
    .wide_action_channel_o(rec_o[263:240]),
    .early_tag_a_i(pat[239:228]), .early_tag_a_o(rec_o[239:228]),
    .early_tag_b_i(pat[227:216]), .early_tag_b_o(rec_o[227:216]),
    .late_tag_a_i(pat[215:204]), .late_tag_a_o(rec_o[215:204]),
    .late_tag_b_i(pat[203:192]), .late_tag_b_o(rec_o[203:192]),
    .egress_acl_hit_vector_i(pat[191:0]),
    .egress_acl_hit_vector_o(rec_o[191:0]),
    .out_valid_o, .switch_taken_flag_o, .route_taken_flag_o,
    .chan_a_matches_vlan1_o, .chan_b_matches_vlan2_o, .nh_req_o, .nh_key_o
  );

  next_hop_model nh_u (
    .sys_clk_i, .rst_i, .rec_valid_i(out_valid_o), .nh_req_i(nh_req_o),
    .nh_key_i(nh_key_o), .lookups_o(lookups), .records_o(records),
    .last_key_o(last_key)
  );

  // Clock and hang guard
  initial begin
    sys_clk_i = 1'b0;
    forever #2 sys_clk_i = ~sys_clk_i;
  end
  always @(posedge sys_clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fails++;
      conclude();
    end
  end

  task automatic chk(input logic [746:0] got, input logic [746:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One APB transfer, entered just after a rising edge
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    psel_i <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i <= wr;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge sys_clk_i);
    penable_i <= 1'b1;
    // Wait states end only on pready or the bench timeout
    do begin
      @(posedge sys_clk_i);
    end while (pready_o !== 1'b1);
    rd = prdata_o;
    err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    @(posedge sys_clk_i);
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(rd, exp);
  endtask

  // One frame through the record path
  task automatic frame(input logic [31:0] s, input logic sw, rt, eq);
    logic [767:0] w;
    w = {24{s}};
    if (eq) begin
      w[291:280] = w[650:639];
      w[275:264] = w[638:627];
    end
    pat <= w[746:0];
    final_switch_i <= sw;
    final_route_i <= rt;
    in_valid_i <= 1'b1;
    @(posedge sys_clk_i);
    in_valid_i <= 1'b0;
    #1;
    chk(out_valid_o, 1'b1);
    chk(rec_o, pat);
    chk(route_taken_flag_o, rt);
    chk(switch_taken_flag_o, sw & ~rt);
    chk(switch_taken_flag_o & route_taken_flag_o, 1'b0);
    chk(chan_a_matches_vlan1_o, pat[291:280] == pat[650:639]);
    chk(chan_b_matches_vlan2_o, pat[275:264] == pat[638:627]);
    chk(nh_req_o, rt);
    if (rt) chk(nh_key_o, pat[263:240]);
    @(posedge sys_clk_i);
  endtask

  task automatic conclude();
    $display("compares=%0d fails=%0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    {rst_i, psel_i, penable_i, pwrite_i, frame_active_i} = 5'b10000;
    {in_valid_i, final_switch_i, final_route_i} = 3'b000;
    paddr_i = '0;
    pwdata_i = '0;
    pat = '0;
    repeat (5) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    apb(1'b1, CAM_MASK_ADDR, 32'h1234_5678);
    rdchk(CAM_MASK_ADDR, 32'h0000_0000);
    chk(cam_slice_enable_mask_o, 32'h0000_0000);
    apb(1'b1, COMMIT_CTRL_ADDR, 32'h0000_0000);
    rdchk(CAM_MASK_ADDR, 32'h0000_0000);
    frame_active_i <= 1'b1;
    apb(1'b1, COMMIT_CTRL_ADDR, 32'h0000_0001);
    repeat (4) @(posedge sys_clk_i);
    chk(cam_slice_enable_mask_o, 32'h0000_0000);
    rdchk(COMMIT_STATUS_ADDR, 32'h0000_0001);
    frame_active_i <= 1'b0;
    repeat (2) @(posedge sys_clk_i);
    chk(cam_slice_enable_mask_o, 32'h1234_5678);
    rdchk(CAM_MASK_ADDR, 32'h1234_5678);
    rdchk(COMMIT_CTRL_ADDR, 32'h0000_0000);
    // Tree group staged then committed together
    apb(1'b1, CAM_MASK_ADDR, 32'h0000_00ff);
    apb(1'b1, TREE_MASK_ADDR, 32'h0000_000a);
    apb(1'b1, CASE_EN_ADDR, 32'h5a5a_0001);
    apb(1'b1, PART_TABLE_ADDR, 32'h0f0f_0002);
    for (int k = 0; k < ROOT_KEYS; k++) begin
      apb(1'b1, ROOT_KEY_BASE_ADDR + 8'(4 * k), 32'h1000_0000 + k);
    end
    chk(tree_top_level_keys_o, '0);
    apb(1'b1, COMMIT_CTRL_ADDR, 32'h0000_0002);
    repeat (2) @(posedge sys_clk_i);
    chk(tree_slice_enable_mask_o, 4'ha);
    chk(tree_case_enable_o, 32'h5a5a_0001);
    chk(tree_root_to_partition_table_o, 32'h0f0f_0002);
    chk(cam_slice_enable_mask_o, 32'h1234_5678);
    for (int k = 0; k < ROOT_KEYS; k++) begin
      chk(tree_top_level_keys_o[k*32+:32], 32'h1000_0000 + k);
      rdchk(ROOT_KEY_BASE_ADDR + 8'(4 * k), 32'h1000_0000 + k);
    end
    apb(1'b1, COMMIT_CTRL_ADDR, 32'h0000_0001);
    repeat (2) @(posedge sys_clk_i);
    chk(cam_slice_enable_mask_o, 32'h0000_00ff);
    // Unmapped place is refused
    apb(1'b1, 8'h3c, 32'hffff_ffff);
    chk(err, 1'b1);
    rdchk(8'h3c, 32'h0000_0000);
    chk(err, 1'b1);
    // Every switch and route combination
    for (int i = 0; i < 4; i++) begin
      frame(32'h3c5a_96e1 + i, i[0], i[1], i[0]);
    end
    // Let the model register the last frame's pulses
    @(posedge sys_clk_i);
    #1;
    chk(lookups, 16'h0002);
    chk(records, 16'h0004);
    chk(last_key, pat[263:240]);
    conclude();
  end
endmodule
